//--- src/pae_top.sv
// process alarm evaluator: registers, display, capture and alarms
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
module pae_top import pae_pkg::*; #(
  parameter int unsigned SEC_CYC = SEC_CYCLES // cycles per timer tick
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // measurement path
  input wire pae_meas_t meas_i,
  // operator pins
  input wire logic key_i,
  input wire logic digital_input_select_i,
  // alarm lines and display
  output logic [NUM_AL-1:0] alarm_o,
  output logic signed [15:0] display_value_o,
  output pae_msg_t display_msg_o,
  // serial link settings
  output logic [2:0] baud_sel_o,
  output logic parity_even_o,
  output logic [7:0] station_address_o
);
  typedef struct packed {
    logic [2:0] key_sync; // two sync stages, then last level
    logic [2:0] din_sync; // same for the digital input
    logic [31:0] func; // function word
    logic signed [15:0] offset; // display offset
    logic signed [15:0] ref_v; // differential reference
    pae_alcfg_t [NUM_AL-1:0] al; // per-alarm settings
    logic [31:0] rdata; // read data, caught in setup
    logic slverr; // unmapped address, caught in setup
    logic [NUM_AL-1:0] cond; // evaluated conditions
    logic upd_d; // update strobe, one cycle late
    logic freeze; // display frozen
    logic signed [15:0] frz_val; // frozen value
    logic pk_load; // next update reloads peak
    logic signed [15:0] pk_val; // captured peak
    logic ext_load; // next update reloads extremes
    logic signed [15:0] max_v; // maximum memory
    logic signed [15:0] min_v; // minimum memory
    logic alt; // message phase of the blink
    logic [31:0] sec_cnt; // tick divider
    logic tick; // one-cycle tick pulse
    logic signed [15:0] disp_val; // shown value
    pae_msg_t disp_msg; // shown message
  } pae_top_st_t;
  pae_top_st_t s, next_s;

  logic f_upd; // filtered value is new
  logic f_fault; // sensor broken
  logic signed [15:0] f_pv; // corrected process value
  logic [NUM_AL-1:0] al_act; // alarm lines after timing
  logic key_act; // key press edge
  logic din_act; // digital input edge
  logic frz_mode; // freeze chosen on a source
  logic pk_mode; // peak chosen on a source
  pae_keysel_t ksel; // function key choice
  pae_keysel_t dsel; // digital input choice

  // correct and smooth the measurement first
  pae_filter u_filter (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .meas_i(meas_i),
    .level_i(s.func[F_FILT +: 6]),
    .offset_i(s.offset),
    .upd_o(f_upd),
    .fault_o(f_fault),
    .pv_o(f_pv)
  );

  // one timer channel per alarm
  for (genvar g = 0; g < NUM_AL; g++) begin : g_al
    pae_alarm u_alarm (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(s.tick),
      .upd_i(s.upd_d),
      .cond_i(s.cond[g]),
      .cfg_i(s.al[g]),
      .active_o(al_act[g])
    );
  end

  // word-aligned addresses that exist
  function automatic logic reg_ok(input logic [7:0] a);
    logic [7:0] o;
    o = a - A_AL0;
    if (a[1:0] != 2'b00) return 1'b0;
    if (a < A_AL0) return 1'b1;
    return a < A_ALEND && o[3:0] != 4'hc;
  endfunction : reg_ok

  // low test; once on it holds up to the point plus the band
  function automatic logic under(input logic signed [17:0] v, t, h,
                                 input logic held);
    return held ? (v <= t + h) : (v < t);
  endfunction : under

  // high test; once on it holds down to the point minus the band
  function automatic logic over(input logic signed [17:0] v, t, h,
                                input logic held);
    return held ? (v >= t - h) : (v > t);
  endfunction : over

  // source choices and edges; the second stage is compared with the last level
  always_comb begin
    ksel = pae_keysel_t'(s.func[F_KEY +: 2]);
    dsel = pae_keysel_t'(s.func[F_DIN +: 2]);
    key_act = s.key_sync[1] & ~s.key_sync[2];
    din_act = s.din_sync[1] & ~s.din_sync[2];
    frz_mode = (ksel == KS_FREEZE) || (dsel == KS_FREEZE);
    pk_mode = (ksel == KS_PEAK) || (dsel == KS_PEAK);
  end

  // all next-state logic of the block
  always_comb begin
    logic [7:0] ao; // offset into alarm blocks
    logic [1:0] ai; // addressed alarm
    logic signed [17:0] pv; // working process value
    logic signed [17:0] rf; // working reference
    logic signed [17:0] sp; // working setpoint
    logic signed [17:0] hb; // working hysteresis
    logic hit; // next condition of one alarm
    ao = paddr_i - A_AL0;
    ai = ao[5:4];
    pv = ext18(f_pv);
    rf = ext18(s.ref_v);
    sp = '0;
    hb = '0;
    hit = 1'b0;
    next_s = s;
    next_s.tick = 1'b0;
    next_s.upd_d = f_upd;
    // pins pass two flops before any logic reads them
    next_s.key_sync = {s.key_sync[1:0], key_i};
    next_s.din_sync = {s.din_sync[1:0], digital_input_select_i};

    // tick divider drives timers and the blink
    if (s.sec_cnt >= SEC_CYC - 1) begin
      next_s.sec_cnt = '0;
      next_s.tick = 1'b1;
      next_s.alt = ~s.alt;
    end else begin
      next_s.sec_cnt = s.sec_cnt + 32'h1;
    end

    // apb setup: read data and error are caught ahead of access
    if (psel_i && !penable_i) begin
      next_s.slverr = ~reg_ok(paddr_i);
      next_s.rdata = '0;
      // words past the last alarm block read as zero, like other holes
      if (paddr_i >= A_AL0 && paddr_i < A_ALEND) begin
        unique case (ao[3:0])
          A_ALCFG: next_s.rdata = {s.al[ai].hyst, 12'h000, s.al[ai].block,
                                   s.al[ai].func};
          A_ALSP: next_s.rdata = {16'h0000, s.al[ai].setpoint};
          A_ALTM: next_s.rdata = {s.al[ai].t2, s.al[ai].t1};
          default: next_s.rdata = '0; // hole or unmapped
        endcase
      end else begin
        unique case (paddr_i)
          A_FUNC: next_s.rdata = s.func;
          A_OFFSET: next_s.rdata = {16'h0000, s.offset};
          A_REF: next_s.rdata = {16'h0000, s.ref_v};
          A_STAT: next_s.rdata = {24'h000000, s.alt, pk_mode, s.freeze,
                                  f_fault, al_act};
          A_PV: next_s.rdata = {16'h0000, f_pv};
          A_MAX: next_s.rdata = {16'h0000, s.max_v};
          A_MIN: next_s.rdata = {16'h0000, s.min_v};
          A_DISP: next_s.rdata = {16'h0000, s.disp_val};
          default: next_s.rdata = '0; // misaligned or past the last alarm block
        endcase
      end
    end

    // apb access: writes land here, read-only words ignore them
    if (psel_i && penable_i && pwrite_i && reg_ok(paddr_i)) begin
      if (paddr_i >= A_AL0) begin
        unique case (ao[3:0])
          A_ALCFG: begin
            next_s.al[ai].func = pae_alfunc_t'(pwdata_i[2:0]);
            next_s.al[ai].block = pwdata_i[3];
            next_s.al[ai].hyst = pwdata_i[31:16];
          end
          A_ALSP: next_s.al[ai].setpoint = pwdata_i[15:0];
          A_ALTM: begin
            next_s.al[ai].t1 = pwdata_i[15:0];
            next_s.al[ai].t2 = pwdata_i[31:16];
          end
          default: next_s.al[ai].t1 = s.al[ai].t1; // hole
        endcase
      end else if (paddr_i == A_FUNC) begin
        // rate, parity, address and source choices kept as written
        next_s.func = {10'h000, pwdata_i[21:0]};
        // filter level clipped to its top setting
        if (pwdata_i[F_FILT +: 6] > FILT_MAX) begin
          next_s.func[F_FILT +: 6] = FILT_MAX;
        end
      end else if (paddr_i == A_OFFSET) begin
        next_s.offset = pwdata_i[15:0];
      end else if (paddr_i == A_REF) begin
        next_s.ref_v = pwdata_i[15:0];
      end
    end

    // alarm conditions, refreshed on each new value
    if (f_upd) begin
      for (int i = 0; i < NUM_AL; i++) begin
        sp = ext18(s.al[i].setpoint);
        hb = {2'b00, s.al[i].hyst};
        hit = 1'b0;
        // a broken sensor only trips the fault function
        unique case (s.al[i].func)
          AF_OFF: hit = 1'b0;
          AF_FAULT: hit = f_fault;
          AF_LO: hit = under(pv, sp, hb, s.cond[i]);
          AF_HI: hit = over(pv, sp, hb, s.cond[i]);
          AF_DEV_LO: hit = under(pv, rf + sp, hb, s.cond[i]);
          AF_DEV_HI: hit = over(pv, rf + sp, hb, s.cond[i]);
          AF_DEV_OUT: hit = under(pv, rf - sp, hb, s.cond[i])
                            || over(pv, rf + sp, hb, s.cond[i]);
          AF_DEV_IN: hit = s.cond[i]
                           ? (pv >= rf - sp - hb && pv <= rf + sp + hb)
                           : (pv > rf - sp && pv < rf + sp);
        endcase
        next_s.cond[i] = hit && (!f_fault || s.al[i].func == AF_FAULT);
      end
    end

    // captures track the corrected value on each update
    if (f_upd) begin
      next_s.pk_load = 1'b0;
      next_s.ext_load = 1'b0;
      if (s.pk_load || f_pv > s.pk_val) next_s.pk_val = f_pv;
      if (s.ext_load || f_pv > s.max_v) next_s.max_v = f_pv;
      if (s.ext_load || f_pv < s.min_v) next_s.min_v = f_pv;
    end

    // source activations; a restart wins over a same-cycle update
    if ((key_act && ksel == KS_PEAK) || (din_act && dsel == KS_PEAK)) begin
      next_s.pk_load = 1'b1;
    end
    if ((key_act && ksel == KS_CLEAR) || (din_act && dsel == KS_CLEAR)) begin
      next_s.ext_load = 1'b1;
    end
    if ((key_act && ksel == KS_FREEZE) || (din_act && dsel == KS_FREEZE)) begin
      next_s.freeze = ~s.freeze;
      next_s.frz_val = f_pv;
    end
    if (!frz_mode) next_s.freeze = 1'b0;

    // display: error over freeze over peak over live value
    if (f_fault) begin
      next_s.disp_val = f_pv;
      next_s.disp_msg = DM_ERROR;
    end else if (s.freeze) begin
      next_s.disp_val = s.frz_val;
      next_s.disp_msg = s.alt ? DM_FREEZE : DM_NONE;
    end else if (pk_mode) begin
      next_s.disp_val = s.pk_val;
      next_s.disp_msg = s.alt ? DM_PEAK : DM_NONE;
    end else begin
      next_s.disp_val = f_pv;
      next_s.disp_msg = DM_NONE;
    end
  end

  // state register; captures reload on their first update
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.func <= FUNC_RST;
      s.offset <= WORD_RST;
      s.ref_v <= WORD_RST;
      s.pk_load <= 1'b1;
      s.ext_load <= 1'b1;
      s.disp_msg <= DM_NONE;
    end else begin
      s <= next_s;
    end
  end

  // zero wait states: the answer was prepared in setup
  assign pready_o = 1'b1;
  assign prdata_o = s.rdata;
  assign pslverr_o = s.slverr;
  // outward levels
  assign alarm_o = al_act;
  assign display_value_o = s.disp_val;
  assign display_msg_o = s.disp_msg;
  assign baud_sel_o = s.func[F_BAUD +: 3];
  assign parity_even_o = s.func[F_PAR];
  assign station_address_o = s.func[F_ADR +: 8];

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  fault_msg_a: assert property (f_fault |=> display_msg_o == DM_ERROR)
    else $error("fault not shown as error");
  filt_limit_a: assert property (s.func[F_FILT +: 6] <= FILT_MAX)
    else $error("filter level above top");
  frz_show_a: assert property (s.freeze && !f_fault
                              |=> display_value_o == $past(s.frz_val))
    else $error("frozen value not shown");
  peak_rise_a: assert property (f_upd && !s.pk_load
                                |=> s.pk_val >= $past(s.pk_val))
    else $error("peak fell without restart");
  ext_order_a: assert property (!s.ext_load |-> s.max_v >= s.min_v)
    else $error("maximum below minimum");
  off_quiet_a: assert property (f_upd && s.al[0].func == AF_OFF
                                |=> !s.cond[0])
    else $error("disabled alarm evaluated true");

  // one activation of either source under a given choice
  sequence frz_hit_s;
    (key_act && ksel == KS_FREEZE) || (din_act && dsel == KS_FREEZE);
  endsequence
  sequence pk_hit_s;
    (key_act && ksel == KS_PEAK) || (din_act && dsel == KS_PEAK);
  endsequence
  sequence clr_hit_s;
    (key_act && ksel == KS_CLEAR) || (din_act && dsel == KS_CLEAR);
  endsequence
  // each activation flips freeze exactly once
  frz_toggle_a: assert property (frz_hit_s |=> s.freeze != $past(s.freeze))
    else $error("freeze did not toggle");
  // a restart must win over an update in the same cycle
  pk_restart_a: assert property (pk_hit_s |=> s.pk_load)
    else $error("peak restart lost");
  ext_clear_a: assert property (clr_hit_s |=> s.ext_load)
    else $error("extreme clear lost");
  // with nothing overriding, the live value is shown
  live_show_a: assert property (!f_fault && !s.freeze && !pk_mode
                                |=> display_value_o == $past(f_pv))
    else $error("live value not shown");
endmodule : pae_top

//--- src/pae_pkg.sv
// package: constants, types and helpers of the process alarm evaluator
// Function
// - four alarms, each with own function choice
// - sensor fault alarm on open or short
// - absolute alarms compare value with own setpoint
// - differential setpoint is deviation from reference
// - one shared reference for differential alarms
// - outside band and inside band differential alarms
// - hysteresis separates turn-on and turn-off points
// - blocking suppresses alarm present at power-up
// - two timers; both zero disables timing
// - filter strength 0 to 60, 0 bypasses
// - signed offset added to process value
// - freeze shows held value alternating with message
// - peak capture shows peak alternating with message
// - function key selects unused, freeze, clear, peak
// - digital input has same four choices
// - serial rate 1200 to 115200, optional even parity
// - station address for multidrop network
// - fault replaces display with error message
// - display starts with process value after power-up
// - freeze activation toggles freeze state
// - peak activation restarts capture with new value
// - clear activation empties max and min memories
package pae_pkg;
  localparam int unsigned CLK_HZ = 25_000_000; // system clock, hertz
  localparam int unsigned SEC_S = 1; // timer and blink unit, seconds
  localparam int unsigned SEC_CYCLES = CLK_HZ * SEC_S; // cycles per unit
  localparam int NUM_AL = 4; // alarm channels
  localparam logic [5:0] FILT_MAX = 6'h3c; // strongest filter level
  // register byte offsets
  localparam logic [7:0] A_FUNC = 8'h00;
  localparam logic [7:0] A_OFFSET = 8'h04;
  localparam logic [7:0] A_REF = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_PV = 8'h10;
  localparam logic [7:0] A_MAX = 8'h14;
  localparam logic [7:0] A_MIN = 8'h18;
  localparam logic [7:0] A_DISP = 8'h1c;
  localparam logic [7:0] A_AL0 = 8'h20; // first alarm block
  localparam logic [7:0] A_ALEND = 8'h60; // past last alarm block
  localparam logic [3:0] A_ALCFG = 4'h0; // within one alarm block
  localparam logic [3:0] A_ALSP = 4'h4;
  localparam logic [3:0] A_ALTM = 4'h8;
  // field positions of the function word
  localparam int F_KEY = 0; // 2 bits
  localparam int F_DIN = 2; // 2 bits
  localparam int F_FILT = 4; // 6 bits
  localparam int F_BAUD = 10; // 3 bits
  localparam int F_PAR = 13; // 1 bit
  localparam int F_ADR = 14; // 8 bits
  // reset values
  localparam logic [31:0] FUNC_RST = 32'h0000_4000; // station 1
  localparam logic [15:0] WORD_RST = 16'h0000; // offset, reference
  typedef enum logic [2:0] {
    AF_OFF = 3'h0, AF_FAULT = 3'h1, AF_LO = 3'h2, AF_HI = 3'h3,
    AF_DEV_LO = 3'h4, AF_DEV_HI = 3'h5, AF_DEV_OUT = 3'h6, AF_DEV_IN = 3'h7
  } pae_alfunc_t;
  typedef enum logic [1:0] {
    KS_UNUSED = 2'h0, KS_FREEZE = 2'h1, KS_CLEAR = 2'h2, KS_PEAK = 2'h3
  } pae_keysel_t;
  typedef enum logic [1:0] {
    DM_NONE = 2'h0, DM_FREEZE = 2'h1, DM_PEAK = 2'h2, DM_ERROR = 2'h3
  } pae_msg_t;
  typedef enum logic [3:0] {
    TS_IDLE = 4'h1, TS_DELAY = 4'h2, TS_ON = 4'h4, TS_DONE = 4'h8
  } pae_tstate_t;
  typedef struct packed {
    pae_alfunc_t func;
    logic block;
    logic [15:0] hyst;
    logic signed [15:0] setpoint;
    logic [15:0] t1;
    logic [15:0] t2;
  } pae_alcfg_t;
  typedef struct packed {
    logic valid;
    logic open_c;
    logic short_c;
    logic signed [15:0] value;
  } pae_meas_t;
  // sign extension to working width
  function automatic logic signed [17:0] ext18(input logic signed [15:0] v);
    return {{2{v[15]}}, v};
  endfunction : ext18
  // clip a working value to the display range
  function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
    if (v > 18'sh07fff) return 16'sh7fff;
    if (v < 18'sh38000) return 16'sh8000;
    return v[15:0];
  endfunction : sat16
endpackage : pae_pkg

//--- src/pae_filter.sv
// measurement filter and offset correction stage
`timescale 1ns/10ps
module pae_filter import pae_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // raw measurement and settings
  input wire pae_meas_t meas_i,
  input wire logic [5:0] level_i,
  input wire logic signed [15:0] offset_i,
  // corrected value
  output logic upd_o,
  output logic fault_o,
  output logic signed [15:0] pv_o
);
  typedef struct packed {
    logic primed; // first sample seen
    logic upd; // one-cycle update strobe
    logic fault; // sensor open or short
    logic signed [23:0] acc; // average, 8 fraction bits
    logic signed [15:0] pv; // corrected value
  } pae_filt_st_t;
  pae_filt_st_t s, next_s;
  logic signed [24:0] diff; // sample minus average
  logic [3:0] shift; // weight of new sample
  // one-pole average; weight halves every eight levels
  always_comb begin
    next_s = s;
    next_s.upd = 1'b0;
    shift = 4'h1 + {1'b0, level_i[5:3]};
    diff = {meas_i.value[15], meas_i.value, 8'h00} - {s.acc[23], s.acc};
    if (meas_i.valid) begin
      next_s.upd = 1'b1;
      next_s.primed = 1'b1;
      next_s.fault = meas_i.open_c | meas_i.short_c;
      // seeding avoids a slow ramp up from zero
      if (level_i == 6'h00 || !s.primed) begin
        next_s.acc = {meas_i.value, 8'h00};
      end else begin
        next_s.acc = s.acc + 24'(diff >>> shift);
      end
      next_s.pv = sat16(ext18(next_s.acc[23:8]) + ext18(offset_i));
    end
  end
  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign upd_o = s.upd;
  assign fault_o = s.fault;
  assign pv_o = s.pv;
endmodule : pae_filter

//--- src/pae_alarm.sv
// one alarm channel: power-up blocking and on/off timers
`timescale 1ns/10ps
module pae_alarm import pae_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // timing and evaluated condition
  input wire logic tick_i,
  input wire logic upd_i,
  input wire logic cond_i,
  input wire pae_alcfg_t cfg_i,
  // alarm line
  output logic active_o
);
  typedef struct packed {
    pae_tstate_t st; // timer phase
    logic blk; // power-up suppression
    logic [15:0] cnt; // remaining ticks
  } pae_al_st_t;
  pae_al_st_t s, next_s;
  logic run; // condition after blocking
  // timer sequence: delay t1, then on for t2 (0 = until cleared)
  always_comb begin
    next_s = s;
    run = cond_i & ~s.blk;
    // blocking lifts once the condition was seen absent
    if (upd_i && s.blk && (!cfg_i.block || !cond_i)) begin
      next_s.blk = 1'b0;
    end
    unique case (s.st)
      TS_IDLE: begin
        if (run && cfg_i.t1 != 16'h0000) begin
          next_s.st = TS_DELAY;
          next_s.cnt = cfg_i.t1;
        end else if (run) begin
          next_s.st = TS_ON;
          next_s.cnt = cfg_i.t2;
        end
      end
      TS_DELAY: begin
        if (!run) begin
          next_s.st = TS_IDLE;
        end else if (tick_i && s.cnt <= 16'h0001) begin
          next_s.st = TS_ON;
          next_s.cnt = cfg_i.t2;
        end else if (tick_i) begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      TS_ON: begin
        if (!run) begin
          next_s.st = TS_IDLE;
        end else if (tick_i && s.cnt != 16'h0000) begin
          // momentary pulse ends, waits for condition to clear
          if (s.cnt == 16'h0001) next_s.st = TS_DONE;
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      TS_DONE: begin
        if (!run) next_s.st = TS_IDLE;
      end
      default: next_s.st = TS_IDLE; // lost one-hot code
    endcase
  end
  // state register; blocked from power-up
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.st <= TS_IDLE;
      s.blk <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  assign active_o = (s.st == TS_ON);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence arm_delay_s;
    s.st == TS_IDLE && run && cfg_i.t1 != 16'h0000;
  endsequence
  sequence wait_off_s;
    !active_o && s.st == TS_DELAY;
  endsequence
  delay_wait_a: assert property (arm_delay_s |=> wait_off_s)
    else $error("alarm skipped its first timer");
  block_hold_a: assert property (s.blk && cfg_i.block |-> !active_o)
    else $error("blocked alarm is active");
  drop_off_a: assert property (!run |=> !active_o)
    else $error("alarm stays on without condition");
endmodule : pae_alarm

//--- bench/pae_sensor_model.sv
// sensor measurement path model: one-cycle samples with fault flags
`timescale 1ns/10ps
module pae_sensor_model import pae_pkg::*; (
  // clock
  input wire logic ref_clk_i,
  // sample toward the block
  output pae_meas_t meas_o
);
  initial meas_o = '0;
  // one sample per call; fields scrambled between samples, never held
  task automatic send(input logic signed [15:0] v, input logic op);
    @(posedge ref_clk_i);
    meas_o <= '{1'b1, op, 1'b0, v};
    @(posedge ref_clk_i);
    meas_o <= '{1'b0, ~op, 1'b1, ~v};
  endtask : send
endmodule : pae_sensor_model

//--- bench/tb_process_alarm_evaluator.sv
// testbench of the process alarm evaluator over its register bus
`timescale 1ns/10ps
module tb_process_alarm_evaluator import pae_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic key = 1'b0, din = 1'b0, prdy, err, serr, par;
  logic [7:0] padr = '0, adr;
  logic [31:0] pwd = '0, rd, prd;
  logic [3:0] alm;
  logic [2:0] baud;
  logic signed [15:0] dval;
  pae_msg_t msg;
  pae_meas_t meas;
  int n_fail = 0, cmp_count = 0;
  // 25 mhz clock
  always #20 clk = ~clk;
  pae_sensor_model sens (.ref_clk_i(clk), .meas_o(meas));
  // short tick keeps timer paths cheap to reach
  pae_top #(.SEC_CYC(8)) dut (.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .pready_o(prdy),
    .prdata_o(prd), .pslverr_o(serr), .meas_i(meas), .key_i(key), .digital_input_select_i(din),
    .alarm_o(alm), .display_value_o(dval), .display_msg_o(msg), .baud_sel_o(baud),
    .parity_even_o(par), .station_address_o(adr));
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rd = prd;
    err = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xfer
  // new sample, then alarm lines after settling
  task automatic step(input logic signed [15:0] v, input logic op, input logic [3:0] e);
    sens.send(v, op);
    repeat (8) @(posedge clk);
    chk(32'(alm), 32'(e));
  endtask : step
  // press key or digital input, long enough for the synchroniser
  task automatic press(input logic k);
    if (k) key <= 1'b1;
    else din <= 1'b1;
    repeat (4) @(posedge clk);
    key <= 1'b0;
    din <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : press
  // a blinking message shows within one blink period, then compare it
  task automatic see(input pae_msg_t m);
    repeat (20) if (msg !== m) @(posedge clk);
    chk(32'(msg), 32'(m));
  endtask : see
  // counts, verdict, end of run
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'(adr), 32'h1);
    chk(32'(msg), 32'(DM_NONE));
    xfer(1'b0, A_FUNC, '0);
    chk(rd, FUNC_RST);
    xfer(1'b0, 8'h2c, '0);
    chk(32'(err), 32'h1); // unmapped word
    xfer(1'b1, A_FUNC, 32'h0025_fc00);
    @(posedge clk);
    chk(32'({adr, par, baud}), 32'({8'h97, 1'b1, 3'h7}));
    $display("settings test done");
    xfer(1'b1, A_OFFSET, 32'h5);
    xfer(1'b1, 8'h20, 32'h000a_000b);
    xfer(1'b1, 8'h24, 32'd50);
    step(16'sd100, 1'b0, 4'h0);
    step(16'sd20, 1'b0, 4'h0);
    step(16'sd100, 1'b0, 4'h1);
    xfer(1'b0, A_PV, '0);
    chk(rd, 32'h69);
    xfer(1'b1, A_OFFSET, '0);
    $display("offset test done");
    xfer(1'b1, A_REF, 32'd200);
    xfer(1'b1, 8'h20, 32'h000a_0003);
    xfer(1'b1, 8'h24, 32'd50);
    xfer(1'b1, 8'h30, 32'h1);
    xfer(1'b1, 8'h40, 32'h6);
    xfer(1'b1, 8'h44, 32'd20);
    xfer(1'b1, 8'h50, 32'h7);
    xfer(1'b1, 8'h54, 32'd20);
    step(16'sd230, 1'b0, 4'b0101);
    step(16'sd45, 1'b0, 4'b0101);
    step(16'sd35, 1'b0, 4'b0100);
    step(16'sd200, 1'b0, 4'b1001);
    $display("alarm test done");
    xfer(1'b1, A_FUNC, 32'h0000_4005);
    press(1'b1);
    step(16'sd300, 1'b0, 4'b0101);
    chk(32'(dval), 32'd200);
    see(DM_FREEZE);
    press(1'b0);
    step(16'sd300, 1'b0, 4'b0101);
    chk(32'(dval), 32'd300);
    chk(32'(msg), 32'(DM_NONE));
    $display("freeze test done");
    xfer(1'b1, A_FUNC, 32'h0000_400b);
    press(1'b1);
    step(16'sd150, 1'b0, 4'b0101);
    step(16'sd120, 1'b0, 4'b0101);
    chk(32'(dval), 32'd150);
    see(DM_PEAK);
    press(1'b0);
    step(16'sd110, 1'b0, 4'b0101);
    step(16'sd130, 1'b0, 4'b0101);
    xfer(1'b0, A_MAX, '0);
    chk(rd, 32'd130);
    xfer(1'b0, A_MIN, '0);
    chk(rd, 32'd110);
    $display("capture test done");
    step(16'sd200, 1'b1, 4'b0010);
    chk(32'(msg), 32'(DM_ERROR));
    $display("fault test done");
    xfer(1'b1, 8'h38, 32'h0002_0003);
    step(16'sd200, 1'b0, 4'b1001);
    step(16'sd200, 1'b1, 4'b0000);
    // delay of three ticks, then on for two ticks, then off
    repeat (23) @(posedge clk);
    chk(32'(alm), 32'h2);
    repeat (16) @(posedge clk);
    chk(32'(alm), 32'h0);
    $display("timer test done");
    xfer(1'b1, A_FUNC, 32'h0000_43f0);
    xfer(1'b0, A_FUNC, '0);
    chk(rd, 32'h0000_43c0);
    xfer(1'b1, A_FUNC, 32'h0000_4080);
    // level 8 moves the average a quarter of the way: 200 to 400
    step(16'sd1000, 1'b0, 4'b0101);
    xfer(1'b0, A_PV, '0);
    chk(rd, 32'd400);
    $display("filter test done");
    stop_test();
  end
endmodule : tb_process_alarm_evaluator
